// ### rtl/ffbm_pkg.sv
// shared constants, codes and helpers of the dual-clock width-matching buffer
// assumes: storage counted in 9-bit lanes, words of 36, 18 or 9 bits
package ffbm_pkg;

    // ----------------------------------------------------------------
    // storage geometry
    // ----------------------------------------------------------------
    localparam int         FFBM_LANE_W   = 9;
    localparam int         FFBM_LANES    = 4;
    localparam int         FFBM_WORD_W   = 36;
    localparam int         FFBM_ADDR_W   = 6;
    localparam int         FFBM_PTR_W    = 7;
    localparam int         FFBM_ENTRIES  = 64;
    localparam logic [6:0] FFBM_DEPTH    = 7'h40;

    // ----------------------------------------------------------------
    // width ratio codes
    // ----------------------------------------------------------------
    localparam logic [3:0] FFBM_BM_36_18 = 4'hB;
    localparam logic [3:0] FFBM_BM_36_9  = 4'hF;
    localparam logic [3:0] FFBM_BM_18_36 = 4'h9;
    localparam logic [3:0] FFBM_BM_9_36  = 4'hD;
    localparam logic [2:0] FFBM_UNITS_36 = 3'h4;
    localparam logic [2:0] FFBM_UNITS_18 = 3'h2;
    localparam logic [2:0] FFBM_UNITS_9  = 3'h1;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  FFBM_ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  FFBM_ADDR_STATUS = 8'h04;
    localparam int          FFBM_CTRL_BM_LSB = 0;
    localparam int          FFBM_CTRL_FALL_THROUGH_SELECT   = 4;
    localparam int          FFBM_STAT_FULL_N = 0;
    localparam int          FFBM_STAT_USED   = 8;
    localparam logic [4:0]  FFBM_CTRL_RESET  = 5'h00;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [6:0] ffbm_bin2gray(input logic [6:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [6:0] ffbm_gray2bin(input logic [6:0] g);
        logic [6:0] b;
        b[6] = g[6];
        for (int i = 5; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    function automatic logic [2:0] ffbm_wr_units(input logic [3:0] code);
        case (code)
            FFBM_BM_18_36: return FFBM_UNITS_18;
            FFBM_BM_9_36:  return FFBM_UNITS_9;
            default:       return FFBM_UNITS_36;
        endcase
    endfunction

    function automatic logic [2:0] ffbm_rd_units(input logic [3:0] code);
        case (code)
            FFBM_BM_36_18: return FFBM_UNITS_18;
            FFBM_BM_36_9:  return FFBM_UNITS_9;
            default:       return FFBM_UNITS_36;
        endcase
    endfunction

endpackage

// ### rtl/ffbm_sync.sv
// two-flop synchroniser for a level or a gray-coded vector
// assumes: input changes at most one bit at a time, or is static
`timescale 1ns/1ns
`default_nettype none

module ffbm_sync #(
    parameter int WIDTH = 7
) (
    input  wire logic             clk_in,   // destination clock
    input  wire logic             srst_in,  // synchronous reset, high
    input  wire logic [WIDTH-1:0] async_in, // value from other domain
    output logic      [WIDTH-1:0] sync_out  // synchronised value
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } ffbm_sync_state_type;

    ffbm_sync_state_type s_q;
    ffbm_sync_state_type s_d;

    always_comb begin
        s_d.stage1 = async_in;
        s_d.stage2 = s_q.stage1;
        if (srst_in) begin
            s_d = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        s_q <= s_d;
    end

    assign sync_out = s_q.stage2;

endmodule // ffbm_sync

`default_nettype wire

// ### rtl/ffbm_top.sv
// dual-clock buffer with width matching, standard and fall-through read
// assumes: write port and APB on clk_in, read port on rd_clk_in
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - full clears one write cycle after sync
// - skew may add one more write cycle
// - empty clears one read cycle after sync
// - skew may add one more read cycle
// - code 1011 writes 36, reads 18
// - code 1111 writes 36, reads 9
// - code 1001 writes 18, reads 36
// - code 1101 writes 9, reads 36
// - output enable gates read data drive
// - fall-through select picks fall-through or standard
module ffbm_top
    import ffbm_pkg::*;
(
    input  wire logic        clk_in,                 // write and bus clock
    input  wire logic        srst_in,                // sync reset, high
    input  wire logic        rd_clk_in,              // read link clock
    input  wire logic        psel_in,                // apb select
    input  wire logic        penable_in,             // apb enable
    input  wire logic        pwrite_in,              // apb direction
    input  wire logic [7:0]  paddr_in,               // apb address
    input  wire logic [31:0] pwdata_in,              // apb write data
    output logic      [31:0] prdata_out,             // apb read data
    output logic             pready_out,             // apb ready
    output logic             pslverr_out,            // apb error
    input  wire logic        write_enable_n_in,      // write request, low
    input  wire logic        write_port_select_n_in, // write select, low
    input  wire logic [35:0] write_data_in,          // write word
    output logic             full_flag_n_out,        // full, low
    input  wire logic        read_enable_n_in,       // read request, low
    input  wire logic        read_port_select_n_in,  // read select, low
    input  wire logic        output_enable_n_in,     // output enable, low
    output logic      [35:0] read_data_out,          // read word
    output logic             read_data_oe_out,       // read data drive
    output logic             empty_flag_n_out        // empty, low
);

    // ----------------------------------------------------------------
    // state of the write domain
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                              wen_n_s1;
        logic                              wen_n_s2;
        logic                              wcs_n_s1;
        logic                              wcs_n_s2;
        logic [FFBM_WORD_W-1:0]            wdata_s1;
        logic [FFBM_WORD_W-1:0]            wdata_s2;
        logic [FFBM_PTR_W-1:0]             wptr_bin;
        logic [FFBM_PTR_W-1:0]             wptr_gray;
        logic                              full_n;
        logic [4:0]                        cfg;
        logic                              pready;
        logic                              pslverr;
        logic [31:0]                       prdata;
        logic [FFBM_ENTRIES-1:0][FFBM_LANE_W-1:0] mem;
    } ffbm_wr_state_type;

    // ----------------------------------------------------------------
    // state of the read domain
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                   ren_n_s1;
        logic                   ren_n_s2;
        logic                   rcs_n_s1;
        logic                   rcs_n_s2;
        logic                   oe_n_s1;
        logic                   oe_n_s2;
        logic [FFBM_PTR_W-1:0]  rptr_bin;
        logic [FFBM_PTR_W-1:0]  rptr_gray;
        logic                   empty_n;
        logic                   valid;
        logic [FFBM_WORD_W-1:0] data;
        logic                   oe;
    } ffbm_rd_state_type;

    ffbm_wr_state_type      w_q;
    ffbm_wr_state_type      w_d;
    ffbm_rd_state_type      r_q;
    ffbm_rd_state_type      r_d;

    logic                   rd_rst;
    logic [FFBM_PTR_W-1:0]  rptr_gray_wr;
    logic [FFBM_PTR_W-1:0]  wptr_gray_rd;
    logic [4:0]             cfg_rd;
    logic [FFBM_PTR_W-1:0]  rptr_bin_wr;
    logic [FFBM_PTR_W-1:0]  wptr_bin_rd;
    logic [2:0]             wr_units;
    logic [2:0]             rd_units;
    logic [FFBM_PTR_W-1:0]  wr_used;
    logic [FFBM_PTR_W-1:0]  rd_avail;
    logic [FFBM_PTR_W-1:0]  rd_avail_next;
    logic                   wr_accept;
    logic                   rd_req;
    logic                   rd_pop;
    logic                   rd_can;
    logic                   apb_access;
    logic [FFBM_WORD_W-1:0] rd_head;

    // ----------------------------------------------------------------
    // domain crossings
    // ----------------------------------------------------------------
    ffbm_sync #(.WIDTH(1)) u_rst_sync (
        .clk_in   (rd_clk_in),
        .srst_in  (1'b0),
        .async_in (srst_in),
        .sync_out (rd_rst)
    );

    ffbm_sync #(.WIDTH(FFBM_PTR_W)) u_rptr_sync (
        .clk_in   (clk_in),
        .srst_in  (srst_in),
        .async_in (r_q.rptr_gray),
        .sync_out (rptr_gray_wr)
    );

    ffbm_sync #(.WIDTH(FFBM_PTR_W)) u_wptr_sync (
        .clk_in   (rd_clk_in),
        .srst_in  (rd_rst),
        .async_in (w_q.wptr_gray),
        .sync_out (wptr_gray_rd)
    );

    // configuration is static while traffic runs, so a plain level sync
    ffbm_sync #(.WIDTH(5)) u_cfg_sync (
        .clk_in   (rd_clk_in),
        .srst_in  (rd_rst),
        .async_in (w_q.cfg),
        .sync_out (cfg_rd)
    );

    // ----------------------------------------------------------------
    // write domain: pins, storage, full flag, apb slave
    // ----------------------------------------------------------------
    always_comb begin
        w_d          = w_q;
        w_d.wen_n_s1 = write_enable_n_in;
        w_d.wen_n_s2 = w_q.wen_n_s1;
        w_d.wcs_n_s1 = write_port_select_n_in;
        w_d.wcs_n_s2 = w_q.wcs_n_s1;
        w_d.wdata_s1 = write_data_in;
        w_d.wdata_s2 = w_q.wdata_s1;
        rptr_bin_wr  = ffbm_gray2bin(rptr_gray_wr);
        wr_units     = ffbm_wr_units(w_q.cfg[3:0]);
        // writes while full are dropped, pointers stay
        wr_accept    = !w_q.wen_n_s2 && !w_q.wcs_n_s2 && w_q.full_n;
        if (wr_accept) begin
            // lane 0 takes the low bits of the word
            for (int i = 0; i < FFBM_LANES; i++) begin
                if (3'(i) < wr_units) begin
                    w_d.mem[6'(w_q.wptr_bin[5:0] + 6'(i))] =
                        w_q.wdata_s2[i*FFBM_LANE_W +: FFBM_LANE_W];
                end
            end
            w_d.wptr_bin = w_q.wptr_bin + {4'h0, wr_units};
        end
        w_d.wptr_gray = ffbm_bin2gray(w_d.wptr_bin);
        // freed space seen one cycle after the read pointer lands
        wr_used    = w_d.wptr_bin - rptr_bin_wr;
        w_d.full_n = (FFBM_DEPTH - wr_used) >= {4'h0, wr_units};

        // apb: one wait state, effect at the completing edge only
        apb_access = psel_in && penable_in;
        if (apb_access && !w_q.pready) begin
            w_d.pready  = 1'b1;
            w_d.pslverr = 1'b0;
            w_d.prdata  = 32'h0000_0000;
            case (paddr_in)
                FFBM_ADDR_CTRL: begin
                    w_d.prdata[4:0] = w_q.cfg;
                end
                FFBM_ADDR_STATUS: begin
                    w_d.prdata[FFBM_STAT_FULL_N] = w_q.full_n;
                    w_d.prdata[FFBM_STAT_USED +: FFBM_PTR_W] =
                        w_q.wptr_bin - rptr_bin_wr;
                end
                default: begin
                    w_d.pslverr = 1'b1;
                end
            endcase
        end else if (w_q.pready) begin
            w_d.pready  = 1'b0;
            w_d.pslverr = 1'b0;
            if (apb_access && pwrite_in && paddr_in == FFBM_ADDR_CTRL) begin
                w_d.cfg = pwdata_in[4:0];
            end
        end

        if (srst_in) begin
            w_d          = '0;
            w_d.wen_n_s1 = 1'b1;
            w_d.wen_n_s2 = 1'b1;
            w_d.wcs_n_s1 = 1'b1;
            w_d.wcs_n_s2 = 1'b1;
            w_d.full_n   = 1'b1;
            w_d.cfg      = FFBM_CTRL_RESET;
        end
    end

    always_ff @(posedge clk_in) begin
        w_q <= w_d;
    end

    // ----------------------------------------------------------------
    // read domain: pins, word assembly, empty flag, mode
    // ----------------------------------------------------------------
    always_comb begin
        r_d          = r_q;
        r_d.ren_n_s1 = read_enable_n_in;
        r_d.ren_n_s2 = r_q.ren_n_s1;
        r_d.rcs_n_s1 = read_port_select_n_in;
        r_d.rcs_n_s2 = r_q.rcs_n_s1;
        r_d.oe_n_s1  = output_enable_n_in;
        r_d.oe_n_s2  = r_q.oe_n_s1;
        wptr_bin_rd  = ffbm_gray2bin(wptr_gray_rd);
        rd_units     = ffbm_rd_units(cfg_rd[3:0]);
        rd_avail     = wptr_bin_rd - r_q.rptr_bin;
        rd_can       = rd_avail >= {4'h0, rd_units};
        rd_req       = !r_q.ren_n_s2 && !r_q.rcs_n_s2;
        rd_pop       = 1'b0;

        // head word, lane 0 in the low bits, unused lanes zero
        rd_head = '0;
        for (int i = 0; i < FFBM_LANES; i++) begin
            if (3'(i) < rd_units) begin
                rd_head[i*FFBM_LANE_W +: FFBM_LANE_W] =
                    w_q.mem[6'(r_q.rptr_bin[5:0] + 6'(i))];
            end
        end

        if (cfg_rd[FFBM_CTRL_FALL_THROUGH_SELECT]) begin
            // fall-through: head word presented without a request
            rd_pop = rd_req && r_q.valid;
            if ((!r_q.valid || rd_pop) && rd_can) begin
                r_d.data     = rd_head;
                r_d.rptr_bin = r_q.rptr_bin + {4'h0, rd_units};
                r_d.valid    = 1'b1;
            end else if (rd_pop) begin
                r_d.valid = 1'b0;
            end
            r_d.empty_n = r_d.valid;
        end else begin
            // standard: a request loads the word on the next edge
            rd_pop = rd_req && r_q.empty_n;
            if (rd_pop) begin
                r_d.data     = rd_head;
                r_d.rptr_bin = r_q.rptr_bin + {4'h0, rd_units};
            end
            r_d.valid = 1'b0;
            r_d.empty_n = 1'b0;
            rd_avail_next = wptr_bin_rd - r_d.rptr_bin;
            if (rd_avail_next >= {4'h0, rd_units}) begin
                r_d.empty_n = 1'b1;
            end
        end
        if (!cfg_rd[FFBM_CTRL_FALL_THROUGH_SELECT]) begin
            rd_avail_next = wptr_bin_rd - r_d.rptr_bin;
        end else begin
            rd_avail_next = rd_avail;
        end
        r_d.rptr_gray = ffbm_bin2gray(r_d.rptr_bin);
        r_d.oe        = !r_q.oe_n_s2;

        if (rd_rst) begin
            r_d          = '0;
            r_d.ren_n_s1 = 1'b1;
            r_d.ren_n_s2 = 1'b1;
            r_d.rcs_n_s1 = 1'b1;
            r_d.rcs_n_s2 = 1'b1;
            r_d.oe_n_s1  = 1'b1;
            r_d.oe_n_s2  = 1'b1;
        end
    end

    always_ff @(posedge rd_clk_in) begin
        r_q <= r_d;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata_out       = w_q.prdata;
    assign pready_out       = w_q.pready;
    assign pslverr_out      = w_q.pslverr;
    assign full_flag_n_out  = w_q.full_n;
    assign read_data_out    = r_q.data;
    assign read_data_oe_out = r_q.oe;
    assign empty_flag_n_out = r_q.empty_n;

endmodule // ffbm_top

`default_nettype wire

// ### testbench/ffbm_top_asserts.sv
// port assertions for the dual-clock width-matching buffer
// assumes: bound to ffbm_top from the bench top file
`timescale 1ns/1ns
`default_nettype none
module ffbm_top_asserts
    import ffbm_pkg::*;
(
    input wire logic        clk_in,             // bus clock
    input wire logic        srst_in,            // reset, high
    input wire logic        rd_clk_in,          // read clock
    input wire logic        psel_in,            // apb select
    input wire logic        penable_in,         // apb enable
    input wire logic        pwrite_in,          // apb direction
    input wire logic [7:0]  paddr_in,           // apb address
    input wire logic [31:0] pwdata_in,          // apb write data
    input wire logic        pready_out,         // apb ready
    input wire logic        pslverr_out,        // apb error
    input wire logic        output_enable_n_in, // output enable, low
    input wire logic [35:0] read_data_out,      // read word
    input wire logic        read_data_oe_out,   // read drive
    input wire logic        empty_flag_n_out,   // empty, low
    input wire logic        full_flag_n_out     // full, low
);
    logic [3:0] cfg_q; // width code as last written
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cfg_q <= 4'h0;
        end else if (psel_in && penable_in && pready_out && pwrite_in
                     && paddr_in == FFBM_ADDR_CTRL) begin
            cfg_q <= pwdata_in[3:0];
        end
    end
    apb_wait_ready_a: assert property (@(posedge clk_in) disable iff (srst_in)
        psel_in && penable_in && !pready_out |=> pready_out) else $error("ready late");
    ready_pulse_a: assert property (@(posedge clk_in) disable iff (srst_in)
        pready_out |=> !pready_out) else $error("ready held");
    unmapped_err_a: assert property (@(posedge clk_in) disable iff (srst_in)
        pready_out |-> pslverr_out == (paddr_in != FFBM_ADDR_CTRL
        && paddr_in != FFBM_ADDR_STATUS)) else $error("bad error flag");
    narrow_18_a: assert property (@(posedge rd_clk_in) disable iff (srst_in)
        cfg_q == FFBM_BM_36_18 && $changed(read_data_out)
        |-> read_data_out[35:18] == 18'h0) else $error("wide x18 read");
    narrow_9_a: assert property (@(posedge rd_clk_in) disable iff (srst_in)
        cfg_q == FFBM_BM_36_9 && $changed(read_data_out)
        |-> read_data_out[35:9] == 27'h0) else $error("wide x9 read");
    oe_off_a: assert property (@(posedge rd_clk_in) disable iff (srst_in)
        output_enable_n_in [*6] |=> !read_data_oe_out) else $error("drives when off");
    oe_on_a: assert property (@(posedge rd_clk_in) disable iff (srst_in)
        !output_enable_n_in [*6] |=> read_data_oe_out) else $error("no drive when on");
    empty_hold_a: assert property (@(posedge rd_clk_in) disable iff (srst_in)
        !empty_flag_n_out |=> $stable(read_data_out) || empty_flag_n_out)
        else $error("read while empty");
    cover property (@(posedge clk_in) pslverr_out);
    cover property (@(posedge rd_clk_in) $rose(empty_flag_n_out));
    cover property (@(posedge clk_in) $fell(full_flag_n_out));
endmodule // ffbm_top_asserts
`default_nettype wire

// ### testbench/ffbm_host.sv
// host logic on the write and read pins of the buffer
// assumes: bench calls push, pop and oe; pins move by nba after edges
`timescale 1ns/1ns
`default_nettype none
module ffbm_host (
    input  wire logic        clk_in,     // write clock
    input  wire logic        rd_clk_in,  // read clock
    input  wire logic        empty_n_in, // empty flag, low
    input  wire logic [35:0] rd_bus_in,  // resolved read bus
    output logic             wen_n_out,  // write enable, low
    output logic             wsel_n_out, // write select, low
    output logic      [35:0] wdata_out,  // write word
    output logic             ren_n_out,  // read enable, low
    output logic             rsel_n_out, // read select, low
    output logic             oe_n_out    // output enable, low
);
    initial begin
        wen_n_out = 1'b1;
        wsel_n_out = 1'b1;
        wdata_out = 36'h0;
        ren_n_out = 1'b1;
        rsel_n_out = 1'b1;
        oe_n_out = 1'b0;
    end
    // idle data shows the inverse of the last word
    task automatic push(input logic [35:0] d);
        @(posedge clk_in);
        wen_n_out <= 1'b0;
        wsel_n_out <= 1'b0;
        wdata_out <= d;
        @(posedge clk_in);
        wen_n_out <= 1'b1;
        wsel_n_out <= 1'b1;
        wdata_out <= ~d;
    endtask
    // reads only when a word is flagged; unknown on a hang
    task automatic pop(output logic [35:0] q);
        int i;
        q = 36'hX_XXXX_XXXX;
        for (i = 0; i < 400 && empty_n_in !== 1'b1; i++) @(posedge rd_clk_in);
        if (empty_n_in === 1'b1) begin
            @(posedge rd_clk_in);
            ren_n_out <= 1'b0;
            rsel_n_out <= 1'b0;
            @(posedge rd_clk_in);
            ren_n_out <= 1'b1;
            rsel_n_out <= 1'b1;
            repeat (5) @(posedge rd_clk_in);
            q = rd_bus_in;
        end
    endtask
    task automatic oe(input logic v);
        @(posedge rd_clk_in);
        oe_n_out <= v;
    endtask
endmodule // ffbm_host
`default_nettype wire

// ### testbench/test_fifo_flags_bus_matching.sv
// self-checking bench for the dual-clock width-matching buffer
// assumes: apb master here, pin traffic through the host model
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module test_fifo_flags_bus_matching
    import ffbm_pkg::*;
;
    logic        clk_in = 1'b0;
    logic        rd_clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        psel_in = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in = 1'b0;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    wire logic [31:0] prdata_out;
    wire logic pready_out, pslverr_out, full_flag_n_out, empty_flag_n_out;
    wire logic read_data_oe_out, wen_n, wsel_n, ren_n, rsel_n, oe_n;
    wire logic [35:0] read_data_out, wdata;
    wire logic [35:0] rd_bus = read_data_oe_out ? read_data_out : 36'hZ_ZZZZ_ZZZZ;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [3:0]  codes [4] = '{FFBM_BM_36_18, FFBM_BM_36_9, FFBM_BM_18_36, FFBM_BM_9_36};
    int          wu [4] = '{4, 4, 2, 1};
    int          ru [4] = '{2, 1, 4, 4};
    localparam logic [35:0] LANES = {9'h1C3, 9'h1C2, 9'h1C1, 9'h1C0};
    always #25 clk_in = ~clk_in;
    initial begin
        #1;
        forever #3 rd_clk_in = ~rd_clk_in;
    end
    ffbm_top u_ffbm_top (
        .clk_in(clk_in), .srst_in(srst_in), .rd_clk_in(rd_clk_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .write_enable_n_in(wen_n),
        .write_port_select_n_in(wsel_n), .write_data_in(wdata),
        .full_flag_n_out(full_flag_n_out), .read_enable_n_in(ren_n),
        .read_port_select_n_in(rsel_n), .output_enable_n_in(oe_n),
        .read_data_out(read_data_out), .read_data_oe_out(read_data_oe_out),
        .empty_flag_n_out(empty_flag_n_out));
    ffbm_host u_ffbm_host (
        .clk_in(clk_in), .rd_clk_in(rd_clk_in), .empty_n_in(empty_flag_n_out),
        .rd_bus_in(rd_bus), .wen_n_out(wen_n), .wsel_n_out(wsel_n), .wdata_out(wdata),
        .ren_n_out(ren_n), .rsel_n_out(rsel_n), .oe_n_out(oe_n));
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int i;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_in);
            if (pready_out === 1'b1) break;
        end
        q = (pready_out === 1'b1) ? prdata_out : 32'hXXXX_XXXX;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        `CHK(q, x)
        `CHK(e, xe)
    endtask
    function automatic logic [35:0] part(input logic [35:0] v, input int j, input int u);
        return (v >> (j * u * 9)) & ((36'h1 << (u * 9)) - 36'h1);
    endfunction
    initial begin
        logic [35:0] q;
        int          k;
        int          j;
        repeat (5) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        `CHK(full_flag_n_out, 1'b1)
        `CHK(empty_flag_n_out, 1'b0)
        `CHK(read_data_oe_out, 1'b1)
        repeat (4) @(posedge clk_in);
        rd_chk(FFBM_ADDR_CTRL, 32'h0000_0000, 1'b0);
        rd_chk(FFBM_ADDR_STATUS, 32'h0000_0001, 1'b0);
        wr(FFBM_ADDR_CTRL, 32'hFFFF_FFFF);
        rd_chk(FFBM_ADDR_CTRL, 32'h0000_001F, 1'b0);
        wr(FFBM_ADDR_CTRL, 32'h0000_0000);
        rd_chk(8'h08, 32'h0000_0000, 1'b1);
        u_ffbm_host.push(36'h9_8765_4321);
        repeat (2) @(posedge clk_in);
        #1;
        `CHK(empty_flag_n_out, 1'b0)
        repeat (5) @(posedge rd_clk_in);
        `CHK(empty_flag_n_out, 1'b1)
        `CHK(rd_bus, 36'h0_0000_0000)
        u_ffbm_host.pop(q);
        `CHK(q, 36'h9_8765_4321)
        for (k = 0; k < 17; k++) u_ffbm_host.push({4{k[8:0] + 9'h0A0}});
        repeat (4) @(posedge clk_in);
        `CHK(full_flag_n_out, 1'b0)
        rd_chk(FFBM_ADDR_STATUS, 32'h0000_4000, 1'b0);
        u_ffbm_host.pop(q);
        `CHK(q, {4{9'h0A0}})
        repeat (5) @(posedge clk_in);
        `CHK(full_flag_n_out, 1'b1)
        for (k = 1; k < 16; k++) begin
            u_ffbm_host.pop(q);
            `CHK(q, {4{k[8:0] + 9'h0A0}})
        end
        repeat (10) @(posedge rd_clk_in);
        `CHK(empty_flag_n_out, 1'b0)
        for (k = 0; k < 4; k++) begin
            wr(FFBM_ADDR_CTRL, {28'h0, codes[k]});
            for (j = 0; j < 4 / wu[k]; j++) u_ffbm_host.push(part(LANES, j, wu[k]));
            for (j = 0; j < 4 / ru[k]; j++) begin
                u_ffbm_host.pop(q);
                `CHK(q, part(LANES, j, ru[k]))
            end
        end
        wr(FFBM_ADDR_CTRL, 32'h0000_0010);
        u_ffbm_host.push(36'h5_A5A5_A5A5);
        repeat (40) @(posedge rd_clk_in);
        `CHK(rd_bus, 36'h5_A5A5_A5A5)
        `CHK(empty_flag_n_out, 1'b1)
        u_ffbm_host.pop(q);
        `CHK(q, 36'h5_A5A5_A5A5)
        repeat (10) @(posedge rd_clk_in);
        `CHK(empty_flag_n_out, 1'b0)
        u_ffbm_host.oe(1'b1);
        repeat (8) @(posedge rd_clk_in);
        `CHK(rd_bus, 36'hZ_ZZZZ_ZZZZ)
        u_ffbm_host.oe(1'b0);
        repeat (8) @(posedge rd_clk_in);
        `CHK(read_data_oe_out, 1'b1)
        conclude();
    end
endmodule // test_fifo_flags_bus_matching
bind ffbm_top ffbm_top_asserts u_ffbm_top_asserts (
    .clk_in(clk_in), .srst_in(srst_in), .rd_clk_in(rd_clk_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .output_enable_n_in(output_enable_n_in), .read_data_out(read_data_out),
    .read_data_oe_out(read_data_oe_out), .empty_flag_n_out(empty_flag_n_out),
    .full_flag_n_out(full_flag_n_out));
`default_nettype wire
